// ### logic/css_pkg.sv
// Constants, types and field layout for clock source selection and start-up timing
// Function
// - Every reset loads the factory trim value into the oscillator trim register by itself.
// - Software may write the oscillator trim register, and the written value retunes the RC oscillator.
// - The reset delay after the 14 clocks always runs from the watchdog oscillator, whatever the system clock.
// - Select code 0010 picks the calibrated RC oscillator, and the fuses ship with that code.
// - A programmed divide-by-eight fuse divides the system clock by 8.
// - The RC source wakes in 6 clocks; reset adds 14 clocks, plus 0, 512 or 8192 watchdog cycles.
// - The start-up delay comes from the start-up field of the select register, loaded from fuses.
// - Start-up code 00 is only honoured while the reset pin disable fuse is not set.
// - The start-up fuses default to code 10, the longest option.
// - Select code 0011 routes the 128kHz oscillator to the clock generator.
// - The 128kHz source uses the same 6 clock wake and 14 clock plus delay reset timing.
// - Select bits 3 to 1 give the crystal mode: 100, 101, 110 or 111 by frequency band.
// - At reset the select and start-up fuses are copied into the select register, which then rules.
// - The millisecond delays count watchdog cycles: 512 for 4.1ms and 8192 for 65ms.
package css_pkg;
	localparam int CNT_W = 14;
	localparam int DIV_W = 3;
	// Register word addresses
	localparam logic [1:0] ADDR_SELECT = 2'h0;
	localparam logic [1:0] ADDR_TRIM = 2'h1;
	localparam logic [1:0] ADDR_STATUS = 2'h2;
	// Select and status register field layout
	localparam int SOURCE_SELECT_FIELD_LSB = 0;
	localparam int STARTUP_DELAY_FIELD_LSB = 4;
	localparam int ST_LSB = 0;
	localparam int RUN_BIT = 3;
	localparam int DIV_BIT = 4;
	localparam int SRC_LSB = 5;
	// Shipped defaults of the fuse copies
	localparam logic [3:0] SOURCE_SELECT_FIELD_DEFAULT = 4'h2;
	localparam logic [1:0] STARTUP_DELAY_FIELD_DEFAULT = 2'h2;
	localparam logic [7:0] TRIM_RESET = 8'h00;
	// Select and start-up codes
	localparam logic [3:0] SOURCE_SELECT_FIELD_RC = 4'h2;
	localparam logic [3:0] SOURCE_SELECT_FIELD_LP = 4'h3;
	localparam logic [1:0] STARTUP_DELAY_FIELD_FAST = 2'h0;
	localparam logic [1:0] STARTUP_DELAY_FIELD_SHORT = 2'h1;
	localparam logic [1:0] STARTUP_DELAY_FIELD_LONG = 2'h2;
	localparam logic [1:0] STARTUP_DELAY_FIELD_RSVD = 2'h3;
	// Cycle counts
	localparam logic [CNT_W-1:0] WAKE_CK_CYCLES = 14'h0006;
	localparam logic [CNT_W-1:0] RESET_CK_CYCLES = 14'h000E;
	localparam int WDT_SHORT_DEFAULT = 512;
	localparam int WDT_LONG_DEFAULT = 8192;
	localparam logic [DIV_W-1:0] DIV_LAST = 3'h7;
	localparam logic [1:0] SETTLE_CYCLES = 2'h2;
	// Fuse inputs, 1 means unprogrammed
	typedef struct packed {
		logic [7:0] trim;
		logic rstdis_n;
		logic div8_n;
		logic [1:0] startup_delay_fuses;
		logic [3:0] sel;
	} css_fuse_t;
	typedef enum logic [2:0] {
		ST_LOAD = 3'b000,
		ST_RESET_CK = 3'b001,
		ST_RESET_WDT = 3'b010,
		ST_RUN = 3'b011,
		ST_SLEEP = 3'b100,
		ST_WAKE = 3'b101,
		ST_HALT = 3'b110
	} css_state_t;
	typedef enum logic [1:0] {
		SRC_RC = 2'b00,
		SRC_LP = 2'b01,
		SRC_XTAL = 2'b10
	} css_src_t;
endpackage

// ### logic/css_top.sv
// Clock source select, start-up delay sequencer and Avalon-MM register slave
`timescale 1ns/1ps
module css_top #(
	parameter int WDT_SHORT_CYCLES = css_pkg::WDT_SHORT_DEFAULT,
	parameter int WDT_LONG_CYCLES = css_pkg::WDT_LONG_DEFAULT
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire css_pkg::css_fuse_t fuses,
	input wire logic rc_osc,
	input wire logic lp_osc,
	input wire logic xtal_osc,
	input wire logic power_down,
	input wire logic [1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic sys_clk_en,
	output logic core_run,
	output logic [7:0] osc_trim,
	output logic [2:0] xtal_mode,
	output css_pkg::css_src_t src_route
);
	localparam int SYNC_W = 20;
	localparam int CNT_W_L = css_pkg::CNT_W;
	// Two-flop synchronisers, plus a third stage for edge detection
	logic [SYNC_W-1:0] sync1;
	logic [SYNC_W-1:0] sync2;
	logic [2:0] osc_d;
	css_pkg::css_fuse_t fuse_s;
	logic rc_tick;
	logic lp_tick;
	logic xtal_tick;
	logic pd_s;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sync1 <= '0;
			sync2 <= '0;
			osc_d <= '0;
		end else begin
			sync1 <= {power_down, xtal_osc, lp_osc, rc_osc, fuses};
			sync2 <= sync1;
			osc_d <= sync2[18:16];
		end
	end
	assign fuse_s = sync2[15:0];
	assign pd_s = sync2[19];
	// Rising edges of each oscillator are its cycles
	assign rc_tick = sync2[16] & ~osc_d[0];
	assign lp_tick = sync2[17] & ~osc_d[1];
	assign xtal_tick = sync2[18] & ~osc_d[2];

	// Control state
	css_pkg::css_state_t state;
	css_pkg::css_state_t next_state;
	logic [3:0] source_select_field;
	logic [3:0] next_source_select_field;
	logic [1:0] startup_delay_field;
	logic [1:0] next_startup_delay_field;
	logic [7:0] next_osc_trim;
	logic div8;
	logic next_div8;
	logic rstdis;
	logic next_rstdis;
	logic [CNT_W_L-1:0] cnt;
	logic [CNT_W_L-1:0] next_cnt;
	logic [1:0] settle;
	logic [1:0] next_settle;
	logic [2:0] div;
	logic [2:0] next_div;
	logic next_sys_clk_en;
	css_pkg::css_src_t next_src_route;
	logic sel_tick;
	logic [CNT_W_L-1:0] wdt_target;
	logic [1:0] eff_sut;
	logic wr_sel;
	logic wr_trim;

	// Source routing from the select field
	always_comb begin
		if (source_select_field == css_pkg::SOURCE_SELECT_FIELD_RC) begin
			next_src_route = css_pkg::SRC_RC;
			sel_tick = rc_tick;
		end else if (source_select_field == css_pkg::SOURCE_SELECT_FIELD_LP) begin
			next_src_route = css_pkg::SRC_LP;
			sel_tick = lp_tick;
		end else begin
			next_src_route = css_pkg::SRC_XTAL;
			sel_tick = xtal_tick;
		end
	end

	// Code 00 falls back to the short delay once the reset pin is disabled
	assign eff_sut = (startup_delay_field == css_pkg::STARTUP_DELAY_FIELD_FAST && rstdis) ? css_pkg::STARTUP_DELAY_FIELD_SHORT : startup_delay_field;
	always_comb begin
		unique case (eff_sut)
			css_pkg::STARTUP_DELAY_FIELD_SHORT: wdt_target = CNT_W_L'(WDT_SHORT_CYCLES);
			css_pkg::STARTUP_DELAY_FIELD_LONG: wdt_target = CNT_W_L'(WDT_LONG_CYCLES);
			default: wdt_target = '0;
		endcase
	end

	// Sequencer, registers and gated clock enable
	always_comb begin
		next_state = state;
		next_source_select_field = source_select_field;
		next_startup_delay_field = startup_delay_field;
		next_osc_trim = osc_trim;
		next_div8 = div8;
		next_rstdis = rstdis;
		next_cnt = cnt;
		next_settle = settle;
		next_div = div;
		next_sys_clk_en = 1'b0;
		if (wr_sel) begin
			next_source_select_field = avs_writedata[css_pkg::SOURCE_SELECT_FIELD_LSB +: 4];
			next_startup_delay_field = avs_writedata[css_pkg::STARTUP_DELAY_FIELD_LSB +: 2];
		end
		if (wr_trim) begin
			next_osc_trim = avs_writedata[7:0];
		end
		unique case (state)
			css_pkg::ST_LOAD: begin
				next_settle = settle + 2'h1;
				if (settle == css_pkg::SETTLE_CYCLES) begin
					next_source_select_field = fuse_s.sel;
					next_startup_delay_field = fuse_s.startup_delay_fuses;
					next_osc_trim = fuse_s.trim;
					next_div8 = ~fuse_s.div8_n;
					next_rstdis = ~fuse_s.rstdis_n;
					next_cnt = '0;
					next_state = (fuse_s.startup_delay_fuses == css_pkg::STARTUP_DELAY_FIELD_RSVD) ? css_pkg::ST_HALT
						: css_pkg::ST_RESET_CK;
				end
			end
			css_pkg::ST_RESET_CK: begin
				if (sel_tick) begin
					next_cnt = cnt + 1'b1;
					if (next_cnt == css_pkg::RESET_CK_CYCLES) begin
						next_cnt = '0;
						next_state = (wdt_target == '0) ? css_pkg::ST_RUN
							: css_pkg::ST_RESET_WDT;
					end
				end
			end
			css_pkg::ST_RESET_WDT: begin
				if (lp_tick) begin
					next_cnt = cnt + 1'b1;
					if (next_cnt == wdt_target) begin
						next_state = css_pkg::ST_RUN;
					end
				end
			end
			css_pkg::ST_RUN: begin
				if (sel_tick) begin
					next_div = div + 3'h1;
					next_sys_clk_en = ~div8 | (div == css_pkg::DIV_LAST);
				end
				if (pd_s) begin
					next_state = css_pkg::ST_SLEEP;
					next_sys_clk_en = 1'b0;
				end else if (wr_sel && next_source_select_field != source_select_field) begin
					// New source: gate and time its start-up
					next_state = css_pkg::ST_WAKE;
					next_cnt = '0;
					next_div = '0;
					next_sys_clk_en = 1'b0;
				end
			end
			css_pkg::ST_SLEEP: begin
				next_cnt = '0;
				if (!pd_s) begin
					next_state = css_pkg::ST_WAKE;
				end
			end
			css_pkg::ST_WAKE: begin
				if (sel_tick) begin
					next_cnt = cnt + 1'b1;
					if (next_cnt == css_pkg::WAKE_CK_CYCLES) begin
						next_state = css_pkg::ST_RUN;
					end
				end
			end
			css_pkg::ST_HALT: begin
				next_state = css_pkg::ST_HALT;
			end
			default: begin
				next_state = css_pkg::ST_HALT;
			end
		endcase
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state <= css_pkg::ST_LOAD;
			source_select_field <= css_pkg::SOURCE_SELECT_FIELD_DEFAULT;
			startup_delay_field <= css_pkg::STARTUP_DELAY_FIELD_DEFAULT;
			osc_trim <= css_pkg::TRIM_RESET;
			div8 <= 1'b1;
			rstdis <= 1'b0;
			cnt <= '0;
			settle <= '0;
			div <= '0;
			sys_clk_en <= 1'b0;
			core_run <= 1'b0;
			src_route <= css_pkg::SRC_RC;
		end else begin
			state <= next_state;
			source_select_field <= next_source_select_field;
			startup_delay_field <= next_startup_delay_field;
			osc_trim <= next_osc_trim;
			div8 <= next_div8;
			rstdis <= next_rstdis;
			cnt <= next_cnt;
			settle <= next_settle;
			div <= next_div;
			sys_clk_en <= next_sys_clk_en;
			core_run <= (next_state == css_pkg::ST_RUN);
			src_route <= next_src_route;
		end
	end
	assign xtal_mode = source_select_field[3:1];

	// Avalon slave: one wait state, read data registered
	logic next_wait;
	logic [31:0] next_rdata;
	logic req;
	assign req = avs_read | avs_write;
	assign wr_sel = avs_write & ~avs_waitrequest & avs_byteenable[0]
		& (avs_address == css_pkg::ADDR_SELECT);
	assign wr_trim = avs_write & ~avs_waitrequest & avs_byteenable[0]
		& (avs_address == css_pkg::ADDR_TRIM);
	always_comb begin
		next_wait = ~(req & avs_waitrequest);
		next_rdata = avs_readdata;
		if (avs_read && avs_waitrequest) begin
			next_rdata = 32'h0000_0000;
			unique case (avs_address)
				css_pkg::ADDR_SELECT: begin
					next_rdata[css_pkg::SOURCE_SELECT_FIELD_LSB +: 4] = source_select_field;
					next_rdata[css_pkg::STARTUP_DELAY_FIELD_LSB +: 2] = startup_delay_field;
				end
				css_pkg::ADDR_TRIM: next_rdata[7:0] = osc_trim;
				css_pkg::ADDR_STATUS: begin
					next_rdata[css_pkg::ST_LSB +: 3] = state;
					next_rdata[css_pkg::RUN_BIT] = core_run;
					next_rdata[css_pkg::DIV_BIT] = div8;
					next_rdata[css_pkg::SRC_LSB +: 2] = src_route;
				end
				default: next_rdata = 32'h0000_0000;
			endcase
		end
	end
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0000_0000;
		end else begin
			avs_waitrequest <= next_wait;
			avs_readdata <= next_rdata;
		end
	end

	// Watchdog edges seen in the reset delay, kept apart from the sequencer count
	logic [CNT_W_L-1:0] wdt_seen;
	logic [CNT_W_L-1:0] next_wdt_seen;
	always_comb begin
		next_wdt_seen = '0;
		if (state == css_pkg::ST_RESET_WDT) begin
			next_wdt_seen = wdt_seen + CNT_W_L'(lp_tick);
		end
	end
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wdt_seen <= '0;
		end else begin
			wdt_seen <= next_wdt_seen;
		end
	end

	// Checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	a_gate_until_run: assert property (!core_run |-> !sys_clk_en)
		else $error("clock enable while gated");
	a_trim_loaded: assert property (state == css_pkg::ST_LOAD && settle == css_pkg::SETTLE_CYCLES
		|=> osc_trim == $past(fuse_s.trim))
		else $error("trim not loaded at reset");
	a_trim_write: assert property (wr_trim |=> osc_trim == $past(avs_writedata[7:0]))
		else $error("trim write lost");
	a_fuse_copy: assert property (state == css_pkg::ST_LOAD && settle == css_pkg::SETTLE_CYCLES
		|=> source_select_field == $past(fuse_s.sel) && startup_delay_field == $past(fuse_s.startup_delay_fuses))
		else $error("fuses not copied");
	a_route_rc: assert property (source_select_field == css_pkg::SOURCE_SELECT_FIELD_RC |=> src_route == css_pkg::SRC_RC)
		else $error("rc not routed");
	a_route_lp: assert property (source_select_field == css_pkg::SOURCE_SELECT_FIELD_LP |=> src_route == css_pkg::SRC_LP)
		else $error("128k not routed");
	a_div_rate: assert property (sys_clk_en && div8 |=> !sys_clk_en [*8])
		else $error("divide by eight too fast");
	a_wdt_count: assert property (state == css_pkg::ST_RESET_WDT ##1 state == css_pkg::ST_RUN
		|-> wdt_seen == wdt_target)
		else $error("wdt delay wrong length");
	a_reset_ck: assert property (state == css_pkg::ST_RESET_CK && next_state != state
		|-> next_cnt == '0 && cnt == css_pkg::RESET_CK_CYCLES - 14'h0001)
		else $error("14 clock delay wrong");
	a_wake_six: assert property (state == css_pkg::ST_WAKE && next_state == css_pkg::ST_RUN
		|-> cnt == css_pkg::WAKE_CK_CYCLES - 14'h0001)
		else $error("wake delay wrong");
	a_code00_lock: assert property (rstdis && startup_delay_field == css_pkg::STARTUP_DELAY_FIELD_FAST
		|-> wdt_target == CNT_W_L'(WDT_SHORT_CYCLES))
		else $error("code 00 honoured with reset pin off");
	a_bus_wait: assert property (req && avs_waitrequest |=> !avs_waitrequest)
		else $error("slave answer late");
	c_reset_to_run: cover property (state == css_pkg::ST_RESET_WDT ##1 state == css_pkg::ST_RUN);
	c_wake: cover property (state == css_pkg::ST_SLEEP ##[1:100] state == css_pkg::ST_WAKE);
	c_switch: cover property (state == css_pkg::ST_RUN && wr_sel ##1 state == css_pkg::ST_WAKE);
	c_div_en: cover property (sys_clk_en && div8);
endmodule

// ### test/css_top_tb_top.sv
// Self-checking bench for clock source select, start-up delays and register access
`timescale 1ns/1ps
module css_top_tb_top;
	localparam int WDT_S = 4;
	localparam int WDT_L = 8;
	logic core_clk = 1'h0;
	logic rst = 1'h1;
	css_pkg::css_fuse_t fuses = '1;
	logic [2:0] osc = 3'h0;
	logic power_down = 1'h0;
	logic [1:0] avs_address = 2'h0;
	logic avs_read = 1'h0;
	logic avs_write = 1'h0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [3:0] avs_byteenable = 4'hF;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic sys_clk_en;
	logic core_run;
	logic [7:0] osc_trim;
	logic [2:0] xtal_mode;
	css_pkg::css_src_t src_route;
	logic [31:0] rd;
	int n_errors = 0;
	int cmp_count = 0;
	int cycles = 0;
	int en_cnt = 0;

	css_top #(.WDT_SHORT_CYCLES(WDT_S), .WDT_LONG_CYCLES(WDT_L)) dut_u (
		.core_clk(core_clk), .rst(rst), .fuses(fuses),
		.rc_osc(osc[0]), .lp_osc(osc[1]), .xtal_osc(osc[2]), .power_down(power_down),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.sys_clk_en(sys_clk_en), .core_run(core_run), .osc_trim(osc_trim),
		.xtal_mode(xtal_mode), .src_route(src_route)
	);

	// Core clock, 40 ns period
	always #20 core_clk = ~core_clk;

	// Enable pulse count and hang ceiling
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (sys_clk_en === 1'h1) en_cnt <= en_cnt + 1;
		if (cycles == 20000) begin
			n_errors = n_errors + 1;
			results();
		end
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count = cmp_count + 1;
		if (seen !== exp) begin
			n_errors = n_errors + 1;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic results();
		if (n_errors == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// One Avalon-MM transfer, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [1:0] addr, input logic [31:0] data,
			input logic [3:0] be);
		@(posedge core_clk);
		avs_address <= addr;
		avs_writedata <= data;
		avs_byteenable <= be;
		avs_write <= wr;
		avs_read <= ~wr;
		do begin
			@(posedge core_clk);
		end while (avs_waitrequest !== 1'h0);
		rd = avs_readdata;
		avs_write <= 1'h0;
		avs_read <= 1'h0;
		// Registered outputs settle one and two edges after the write lands
		repeat (2) @(posedge core_clk);
	endtask

	// Oscillator cycles: 3 clocks high, 3 low, then time for the synchroniser
	task automatic pulse(input int which, input int n);
		repeat (n) begin
			osc[which] <= 1'h1;
			repeat (3) @(posedge core_clk);
			osc[which] <= 1'h0;
			repeat (3) @(posedge core_clk);
		end
		repeat (5) @(posedge core_clk);
	endtask

	// The clock stays gated one edge short of the count and opens on the last
	task automatic start(input int which, input int n);
		pulse(which, n - 1);
		check("core_run early", core_run, 1'h0);
		pulse(which, 1);
		check("core_run", core_run, 1'h1);
	endtask

	task automatic do_reset(input logic [3:0] sel, input logic [1:0] startup_delay_fuses, input logic rs_n,
			input logic dv_n);
		rst <= 1'h1;
		fuses <= {8'h5A, rs_n, dv_n, startup_delay_fuses, sel};
		repeat (3) @(posedge core_clk);
		rst <= 1'h0;
		repeat (6) @(posedge core_clk);
	endtask

	// Reset with given fuses, then the 14-edge and watchdog phases
	task automatic boot(input logic [3:0] sel, input logic [1:0] startup_delay_fuses, input logic rs_n,
			input logic dv_n, input int nwdt);
		int src;
		int e0;
		src = (sel == css_pkg::SOURCE_SELECT_FIELD_LP) ? 1 : 0;
		do_reset(sel, startup_delay_fuses, rs_n, dv_n);
		check("osc_trim", osc_trim, 32'h0000_005A);
		bus(1'h0, css_pkg::ADDR_SELECT, 32'h0000_0000, 4'hF);
		check("select", rd[5:0], {startup_delay_fuses, sel});
		check("route", src_route, src);
		pulse(src, 13);
		check("core_run 13", core_run, 1'h0);
		if (nwdt == 0) begin
			start(src, 1);
		end else begin
			pulse(src, 1);
			start(1, nwdt);
		end
		e0 = en_cnt;
		pulse(src, 16);
		check("sys_clk_en", en_cnt - e0, dv_n ? 16 : 2);
		bus(1'h0, css_pkg::ADDR_STATUS, 32'h0000_0000, 4'hF);
		check("status", rd[6:0], {src[1:0], ~dv_n, 1'h1, 3'h3});
	endtask

	// Main sequence
	initial begin
		boot(css_pkg::SOURCE_SELECT_FIELD_RC, css_pkg::STARTUP_DELAY_FIELD_SHORT, 1'h1, 1'h0, WDT_S);
		bus(1'h1, css_pkg::ADDR_TRIM, 32'h0000_00C3, 4'hF);
		check("osc_trim", osc_trim, 32'h0000_00C3);
		bus(1'h1, css_pkg::ADDR_TRIM, 32'h0000_0011, 4'hE);
		bus(1'h0, css_pkg::ADDR_TRIM, 32'h0000_0000, 4'hF);
		check("trim read", rd, 32'h0000_00C3);
		bus(1'h1, css_pkg::ADDR_STATUS, 32'h0000_0000, 4'hF);
		bus(1'h0, css_pkg::ADDR_STATUS, 32'h0000_0000, 4'hF);
		check("status ro", rd[3:0], 4'hB);
		bus(1'h1, 2'h3, 32'h0000_00FF, 4'hF);
		bus(1'h0, 2'h3, 32'h0000_0000, 4'hF);
		check("unmapped", rd, 32'h0000_0000);
		bus(1'h1, css_pkg::ADDR_SELECT, {26'h0, css_pkg::STARTUP_DELAY_FIELD_SHORT, css_pkg::SOURCE_SELECT_FIELD_LP}, 4'hF);
		check("route lp", src_route, css_pkg::SRC_LP);
		start(1, 6);
		for (int m = 4; m < 8; m++) begin
			bus(1'h1, css_pkg::ADDR_SELECT, {26'h0, css_pkg::STARTUP_DELAY_FIELD_SHORT, m[2:0], 1'h0}, 4'hF);
			check("xtal_mode", xtal_mode, m);
			check("route xtal", src_route, css_pkg::SRC_XTAL);
		end
		start(2, 6);
		bus(1'h1, css_pkg::ADDR_SELECT, {26'h0, css_pkg::STARTUP_DELAY_FIELD_SHORT, css_pkg::SOURCE_SELECT_FIELD_RC}, 4'hF);
		check("route rc", src_route, css_pkg::SRC_RC);
		start(0, 6);
		power_down <= 1'h1;
		repeat (6) @(posedge core_clk);
		check("sleep", core_run, 1'h0);
		power_down <= 1'h0;
		repeat (5) @(posedge core_clk);
		start(0, 6);
		boot(css_pkg::SOURCE_SELECT_FIELD_LP, css_pkg::STARTUP_DELAY_FIELD_LONG, 1'h1, 1'h1, WDT_L);
		boot(css_pkg::SOURCE_SELECT_FIELD_RC, css_pkg::STARTUP_DELAY_FIELD_FAST, 1'h1, 1'h0, 0);
		boot(css_pkg::SOURCE_SELECT_FIELD_RC, css_pkg::STARTUP_DELAY_FIELD_FAST, 1'h0, 1'h1, WDT_S);
		do_reset(css_pkg::SOURCE_SELECT_FIELD_RC, css_pkg::STARTUP_DELAY_FIELD_RSVD, 1'h1, 1'h1);
		pulse(0, 20);
		pulse(1, 12);
		check("reserved", core_run, 1'h0);
		bus(1'h0, css_pkg::ADDR_STATUS, 32'h0000_0000, 4'hF);
		check("halt", rd[2:0], 3'h6);
		results();
	end
endmodule
